/* File: rtl/uun_consts.svh */
`ifndef UUN_CONSTS_SVH
`define UUN_CONSTS_SVH

// parameter map: index and subindex of each scaling word
`define UUN_IDX_MOTION      16'h001D
`define UUN_SIDX_FIRST      8'h07
`define UUN_SIDX_LAST       8'h0C
`define UUN_IDX_STATUS      16'h001F
`define UUN_SIDX_RESIDUAL   8'h25

// reset values of the three numerator/denominator pairs
`define UUN_POS_NUM_RST     32'h00000001
`define UUN_POS_DEN_RST     32'h00004000
`define UUN_VEL_NUM_RST     32'h00000001
`define UUN_VEL_DEN_RST     32'h00000001
`define UUN_ACC_NUM_RST     32'h00000001
`define UUN_ACC_DEN_RST     32'h00000001

// fixed sensor resolution: 16384 increments per turn, a power of two
`define UUN_MOTOR_RES       32'h00004000
`define UUN_MOTOR_SHIFT     14

// datapath widths of the multiply-then-divide engine
`define UUN_DVD_W           80
`define UUN_DVS_W           48

// divider latency: start to done, in clock cycles
`define UUN_DIV_CYCLES      81

`endif

/* File: rtl/uun_pkg.sv */
`default_nettype none
package uun_pkg;
  // quantity selector of a conversion
  typedef enum logic [1:0] {
    UUN_QTY_POS,
    UUN_QTY_VEL,
    UUN_QTY_ACC
  } uun_qty_t;

  // owner of the conversion in flight
  typedef enum logic [1:0] {
    UUN_OP_HOST,
    UUN_OP_RES1,
    UUN_OP_RES2
  } uun_op_t;

  // conversion sequencer states
  typedef enum {
    UUN_ST_IDLE,
    UUN_ST_LOAD,
    UUN_ST_DIV
  } uun_state_t;
endpackage
`default_nettype wire

/* File: rtl/uun_div.sv */
`timescale 1ns/100ps
`default_nettype none
`include "uun_consts.svh"
// iterative restoring divider, one quotient bit per clock
module uun_div #(
  parameter int N_W = 80,
  parameter int D_W = 48
) (
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire logic           i_start,
  input  wire logic [N_W-1:0] i_dvd,
  input  wire logic [D_W-1:0] i_dvs,
  output logic                o_done,
  output logic [N_W-1:0]      o_quo
);
  import uun_pkg::*;
  localparam int CW = $clog2(N_W + 1);

  logic [D_W-1:0] rem_q, rem_d;     // partial remainder
  logic [N_W-1:0] quo_q, quo_d;     // dividend shifts out, quotient in
  logic [D_W-1:0] dvs_q, dvs_d;     // held divisor
  logic [CW-1:0]  cnt_q, cnt_d;     // iterations left
  logic           done_q, done_d;   // one-cycle finish pulse
  logic [D_W:0]   trial;            // remainder with next dividend bit
  logic [D_W:0]   diff;             // trial minus divisor

  // next-state: one shift-subtract step per cycle while counting
  always_comb begin
    rem_d  = rem_q;
    quo_d  = quo_q;
    dvs_d  = dvs_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    trial  = {rem_q, quo_q[N_W-1]};
    diff   = trial - {1'b0, dvs_q};
    if (i_start) begin
      rem_d = '0;
      quo_d = i_dvd;
      dvs_d = i_dvs;
      cnt_d = CW'(N_W);
    end else if (cnt_q != '0) begin
      // restore when the trial is below the divisor
      if (trial >= {1'b0, dvs_q}) begin
        rem_d = diff[D_W-1:0];
        quo_d = {quo_q[N_W-2:0], 1'b1};
      end else begin
        rem_d = trial[D_W-1:0];
        quo_d = {quo_q[N_W-2:0], 1'b0};
      end
      cnt_d  = cnt_q - 1'b1;
      done_d = (cnt_q == CW'(1));
    end
  end

  // registers only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rem_q  <= '0;
      quo_q  <= '0;
      dvs_q  <= '0;
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      rem_q  <= rem_d;
      quo_q  <= quo_d;
      dvs_q  <= dvs_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;
  assign o_quo  = quo_q;

  a_div_latency: assert property (@(posedge clk) disable iff (!nrst)
    i_start |-> ##81 o_done)
    else $error("divider finish not 81 cycles after start");
endmodule
`default_nettype wire

/* File: rtl/uun_sat.sv */
`timescale 1ns/100ps
`default_nettype none
`include "uun_consts.svh"
// signs a wide magnitude and clamps it into a signed 32-bit word
module uun_sat (
  input  wire logic [`UUN_DVD_W-1:0] i_mag,
  input  wire logic                  i_neg,
  output logic [31:0]                o_val,
  output logic                       o_ovf
);
  import uun_pkg::*;
  localparam logic [`UUN_DVD_W-1:0] POS_MAX = `UUN_DVD_W'(32'h7FFFFFFF);
  localparam logic [`UUN_DVD_W-1:0] NEG_MAX = `UUN_DVD_W'(33'h080000000);

  // clamp, since a coarse ratio can blow a 32-bit operand far out of range
  always_comb begin
    o_ovf = 1'b0;
    if (i_neg) begin
      if (i_mag > NEG_MAX) begin
        o_val = 32'h80000000;
        o_ovf = 1'b1;
      end else begin
        o_val = 32'h00000000 - i_mag[31:0];
      end
    end else if (i_mag > POS_MAX) begin
      o_val = 32'h7FFFFFFF;
      o_ovf = 1'b1;
    end else begin
      o_val = i_mag[31:0];
    end
  end
endmodule
`default_nettype wire

/* File: rtl/uun_norm.sv */
// Contract
// - convert user units to motor units and back
// - keep values in user units, scale on use
// - sensor resolution is fixed, not writable
// - position default: one unit per increment
// - speed default: one unit per rpm
// - acceleration default: one unit per rpm/s
// - each factor is a numerator/denominator pair
// - position ratio is turns per user unit
// - equal resolution reaches every motor position
// - finer user grid moves in unit groups
// - coarser user grid moves in increment blocks
// - work at motor resolution, pick nearest position
// - signed 32-bit residual to nearest user position
`timescale 1ns/100ps
`default_nettype none
`include "uun_consts.svh"
module uun_norm (
  input  wire logic             I_SYS_CLK,
  input  wire logic             I_NRST,
  input  wire logic             I_PAR_WR,
  input  wire logic             I_PAR_RD,
  input  wire logic [15:0]      I_PAR_IDX,
  input  wire logic [7:0]       I_PAR_SIDX,
  input  wire logic [31:0]      I_PAR_WDATA,
  output logic                  O_PAR_ACK,
  output logic                  O_PAR_ERR,
  output logic [31:0]           O_PAR_RDATA,
  input  wire logic             I_CONV_REQ,
  input  wire uun_pkg::uun_qty_t I_CONV_QTY,
  input  wire logic             I_CONV_TO_USER,
  input  wire logic [31:0]      I_CONV_VAL,
  output logic                  O_CONV_READY,
  output logic                  O_CONV_DONE,
  output logic                  O_CONV_ERR,
  output logic [31:0]           O_CONV_RES,
  input  wire logic [31:0]      I_ACT_POS,
  output logic [31:0]           O_RESIDUAL
);
  import uun_pkg::*;

  // ---- parameter access ----
  logic [31:0] num_q  [3];          // active numerators
  logic [31:0] num_d  [3];
  logic [31:0] den_q  [3];          // active denominators
  logic [31:0] den_d  [3];
  logic [31:0] pend_q [3];          // numerator waiting for its denominator
  logic [31:0] pend_d [3];
  logic        ack_q, ack_d;        // access answer pulse
  logic        perr_q, perr_d;      // access refused
  logic [31:0] rdata_q, rdata_d;    // read data
  logic        map_hit;             // index/subindex inside the factor block
  logic        res_hit;             // residual word
  logic [7:0]  sidx_off;            // subindex relative to the first factor
  logic [1:0]  qsel;                // which pair is addressed
  logic        is_den;              // denominator word of the pair
  logic        wr_ok;               // write value inside the legal range
  logic [31:0] resid_q, resid_d;    // last residual

  // address decode: odd subindex is a numerator, even a denominator
  always_comb begin
    map_hit  = (I_PAR_IDX == `UUN_IDX_MOTION) && (I_PAR_SIDX >= `UUN_SIDX_FIRST)
               && (I_PAR_SIDX <= `UUN_SIDX_LAST);
    res_hit  = (I_PAR_IDX == `UUN_IDX_STATUS) && (I_PAR_SIDX == `UUN_SIDX_RESIDUAL);
    sidx_off = I_PAR_SIDX - `UUN_SIDX_FIRST;
    qsel     = sidx_off[2:1];
    is_den   = sidx_off[0];
    // position words take any nonzero value, speed and accel only positive
    if (qsel == 2'(UUN_QTY_POS)) begin
      wr_ok = (I_PAR_WDATA != 32'h00000000);
    end else begin
      wr_ok = !I_PAR_WDATA[31] && (I_PAR_WDATA != 32'h00000000);
    end
  end

  // next values of the factor registers and the access answer
  always_comb begin
    num_d   = num_q;
    den_d   = den_q;
    pend_d  = pend_q;
    ack_d   = I_PAR_WR || I_PAR_RD;
    perr_d  = 1'b0;
    rdata_d = rdata_q;
    if (I_PAR_WR) begin
      if (!map_hit || !wr_ok) begin
        perr_d = 1'b1;            // unmapped, read-only or out of range
      end else if (!is_den) begin
        pend_d[qsel] = I_PAR_WDATA;
      end else begin
        num_d[qsel] = pend_q[qsel];
        den_d[qsel] = I_PAR_WDATA;
      end
    end else if (I_PAR_RD) begin
      if (map_hit) begin
        rdata_d = is_den ? den_q[qsel] : num_q[qsel];
      end else if (res_hit) begin
        rdata_d = resid_q;
      end else begin
        rdata_d = 32'h00000000;
        perr_d  = 1'b1;
      end
    end
  end

  // factor and access-answer registers; async reset only loads constants
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      num_q[0]  <= `UUN_POS_NUM_RST;
      den_q[0]  <= `UUN_POS_DEN_RST;
      pend_q[0] <= `UUN_POS_NUM_RST;
      num_q[1]  <= `UUN_VEL_NUM_RST;
      den_q[1]  <= `UUN_VEL_DEN_RST;
      pend_q[1] <= `UUN_VEL_NUM_RST;
      num_q[2]  <= `UUN_ACC_NUM_RST;
      den_q[2]  <= `UUN_ACC_DEN_RST;
      pend_q[2] <= `UUN_ACC_NUM_RST;
      ack_q     <= 1'b0;
      perr_q    <= 1'b0;
      rdata_q   <= 32'h00000000;
    end else begin
      num_q     <= num_d;
      den_q     <= den_d;
      pend_q    <= pend_d;
      ack_q     <= ack_d;
      perr_q    <= perr_d;
      rdata_q   <= rdata_d;
    end
  end

  assign O_PAR_ACK   = ack_q;
  assign O_PAR_ERR   = perr_q;
  assign O_PAR_RDATA = rdata_q;

  // ---- conversion engine ----
  uun_state_t             state_q, state_d;   // sequencer
  uun_op_t                op_q, op_d;         // owner of the job
  uun_qty_t               qty_q, qty_d;       // quantity being scaled
  logic                   tou_q, tou_d;       // direction: to user units
  logic [31:0]            val_q, val_d;       // operand
  logic [31:0]            act_q, act_d;       // position snapshot for residual
  logic [31:0]            res_q, res_d;       // host result
  logic                   done_q, done_d;     // host finish pulse
  logic                   cerr_q, cerr_d;     // host result clamped
  logic [31:0]            mag_val;            // operand magnitudes
  logic [31:0]            mag_num;
  logic [31:0]            mag_den;
  logic [63:0]            prod;               // operand times one side of the ratio
  logic [`UUN_DVD_W-1:0]  dvd;                // rounded dividend
  logic [`UUN_DVS_W-1:0]  dvs;                // divisor
  logic                   neg;                // sign of the result
  logic                   div_start;
  logic                   div_done;
  logic [`UUN_DVD_W-1:0]  div_quo;
  logic [31:0]            sat_val;
  logic                   sat_ovf;

  // operand preparation from the registered job
  always_comb begin
    mag_val = val_q[31] ? 32'h00000000 - val_q : val_q;
    mag_num = num_q[qty_q][31] ? 32'h00000000 - num_q[qty_q] : num_q[qty_q];
    mag_den = den_q[qty_q][31] ? 32'h00000000 - den_q[qty_q] : den_q[qty_q];
    neg     = val_q[31] ^ num_q[qty_q][31] ^ den_q[qty_q][31];
    prod    = tou_q ? mag_val * mag_den : mag_val * mag_num;
    if (tou_q) begin
      dvd = `UUN_DVD_W'(prod);
      dvs = (qty_q == UUN_QTY_POS) ? `UUN_DVS_W'({mag_num, 14'h0000})
                                   : `UUN_DVS_W'(mag_num);
    end else begin
      dvd = (qty_q == UUN_QTY_POS) ? `UUN_DVD_W'({prod, 14'h0000})
                                   : `UUN_DVD_W'(prod);
      dvs = `UUN_DVS_W'(mag_den);
    end
    dvd = dvd + `UUN_DVD_W'(dvs >> 1);
  end

  // divider starts on the cycle after a job is latched
  assign div_start = (state_q == UUN_ST_LOAD);

  uun_div #(
    .N_W (`UUN_DVD_W),
    .D_W (`UUN_DVS_W)
  ) u_div (
    .clk     (I_SYS_CLK),
    .nrst    (I_NRST),
    .i_start (div_start),
    .i_dvd   (dvd),
    .i_dvs   (dvs),
    .o_done  (div_done),
    .o_quo   (div_quo)
  );

  uun_sat u_sat (
    .i_mag (div_quo),
    .i_neg (neg),
    .o_val (sat_val),
    .o_ovf (sat_ovf)
  );

  // sequencer: host jobs win, idle time refreshes the residual
  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    qty_d   = qty_q;
    tou_d   = tou_q;
    val_d   = val_q;
    act_d   = act_q;
    res_d   = res_q;
    cerr_d  = cerr_q;
    resid_d = resid_q;
    done_d  = 1'b0;
    case (state_q)
      UUN_ST_IDLE: begin
        if (I_CONV_REQ) begin
          op_d  = UUN_OP_HOST;
          qty_d = I_CONV_QTY;
          tou_d = I_CONV_TO_USER;
          val_d = I_CONV_VAL;
        end else begin
          // first step of the residual: motor position to user grid
          op_d  = UUN_OP_RES1;
          qty_d = UUN_QTY_POS;
          tou_d = 1'b1;
          val_d = I_ACT_POS;
          act_d = I_ACT_POS;
        end
        state_d = UUN_ST_LOAD;
      end
      UUN_ST_LOAD: begin
        state_d = UUN_ST_DIV;
      end
      UUN_ST_DIV: begin
        if (div_done) begin
          case (op_q)
            UUN_OP_HOST: begin
              res_d   = sat_val;
              cerr_d  = sat_ovf;
              done_d  = 1'b1;
              state_d = UUN_ST_IDLE;
            end
            UUN_OP_RES1: begin
              op_d    = UUN_OP_RES2;
              tou_d   = 1'b0;
              val_d   = sat_val;
              state_d = UUN_ST_LOAD;
            end
            default: begin
              resid_d = act_q - sat_val;
              state_d = UUN_ST_IDLE;
            end
          endcase
        end
      end
      default: begin
        state_d = UUN_ST_IDLE;
      end
    endcase
  end

  // engine registers
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_q <= UUN_ST_IDLE;
      op_q    <= UUN_OP_HOST;
      qty_q   <= UUN_QTY_POS;
      tou_q   <= 1'b0;
      val_q   <= 32'h00000000;
      act_q   <= 32'h00000000;
      res_q   <= 32'h00000000;
      done_q  <= 1'b0;
      cerr_q  <= 1'b0;
      resid_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      qty_q   <= qty_d;
      tou_q   <= tou_d;
      val_q   <= val_d;
      act_q   <= act_d;
      res_q   <= res_d;
      done_q  <= done_d;
      cerr_q  <= cerr_d;
      resid_q <= resid_d;
    end
  end

  assign O_CONV_READY = (state_q == UUN_ST_IDLE);
  assign O_CONV_DONE  = done_q;
  assign O_CONV_ERR   = cerr_q;
  assign O_CONV_RES   = res_q;
  assign O_RESIDUAL   = resid_q;

  // ---- checks ----
  sequence s_host_take;
    I_CONV_REQ && O_CONV_READY;
  endsequence
  // done and ready rise together, since the finishing edge also returns the sequencer to idle
  sequence s_host_done;
    !O_CONV_DONE && !O_CONV_READY ##1 O_CONV_DONE && O_CONV_READY;
  endsequence

  a_conv_latency: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    s_host_take |-> ##82 s_host_done)
    else $error("host conversion did not finish 83 cycles after take");

  a_par_answer: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    (I_PAR_WR || I_PAR_RD) |=> O_PAR_ACK)
    else $error("parameter access not answered next cycle");

  a_pair_commit: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    (I_PAR_WR && map_hit && wr_ok && is_den && qsel == 2'(UUN_QTY_POS))
    |=> den_q[0] == $past(I_PAR_WDATA) && num_q[0] == $past(pend_q[0]))
    else $error("position pair not committed on denominator write");

  a_num_held: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    (I_PAR_WR && map_hit && !is_den) |=> $stable(num_q[0]) && $stable(num_q[1]))
    else $error("active numerator changed without denominator");

  a_sensor_fixed: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    (I_PAR_WR && !map_hit) |=> O_PAR_ERR && $stable(den_q[0]))
    else $error("write outside factor block not refused");

  a_pos_default: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    $rose(I_NRST) |-> num_q[0] == `UUN_POS_NUM_RST && den_q[0] == `UUN_POS_DEN_RST)
    else $error("position ratio not at default after reset");

  a_vel_default: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    $rose(I_NRST) |-> num_q[1] == `UUN_VEL_NUM_RST && den_q[1] == `UUN_VEL_DEN_RST)
    else $error("speed ratio not at default after reset");

  a_acc_default: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    $rose(I_NRST) |-> num_q[2] == `UUN_ACC_NUM_RST && den_q[2] == `UUN_ACC_DEN_RST)
    else $error("accel ratio not at default after reset");

  a_resid_hold: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    !(state_q == UUN_ST_DIV && op_q == UUN_OP_RES2 && div_done) |=> $stable(O_RESIDUAL))
    else $error("residual changed outside its refresh step");
endmodule
`default_nettype wire

/* File: tb/uun_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// parameter-port master: one strobe per access, answer sampled one edge later
module uun_host_model (
  input  wire logic        i_clk,
  output logic             o_wr,
  output logic             o_rd,
  output logic [15:0]      o_idx,
  output logic [7:0]       o_sidx,
  output logic [31:0]      o_wdata,
  input  wire logic        i_ack,
  input  wire logic        i_err,
  input  wire logic [31:0] i_rdata
);
  // lines idle low at time zero
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_idx   = 16'h0000;
    o_sidx  = 8'h00;
    o_wdata = 32'h00000000;
  end

  // single access; address and data are inverted once released so stale values never match
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sidx,
                        input logic [31:0] data, output logic ack, output logic err, output logic [31:0] rdata);
    @(posedge i_clk);
    o_wr    <= wr;
    o_rd    <= !wr;
    o_idx   <= idx;
    o_sidx  <= sidx;
    o_wdata <= data;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_rd    <= 1'b0;
    o_idx   <= ~idx;
    o_sidx  <= ~sidx;
    o_wdata <= ~data;
    @(negedge i_clk);
    ack   = i_ack;
    err   = i_err;
    rdata = i_rdata;
  endtask

  task automatic set_ratio(input logic [7:0] sidx_num, input logic [31:0] num, input logic [31:0] den,
                           output logic err);
    logic a, e1, e2;
    logic [31:0] r;
    access(1'b1, 16'h001D, sidx_num, num, a, e1, r);
    access(1'b1, 16'h001D, sidx_num + 8'h01, den, a, e2, r);
    err = e1 | e2;
  endtask
endmodule
`default_nettype wire

/* File: tb/uun_norm_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module uun_norm_bench;
  import uun_pkg::*;
  logic        clk, nrst, par_wr, par_rd, par_ack, par_err;
  logic [15:0] par_idx;
  logic [7:0]  par_sidx;
  logic [31:0] par_wdata, par_rdata, conv_val, conv_res, act_pos, residual;
  logic        conv_req, conv_dir, conv_ready, conv_done, conv_err;
  uun_qty_t    conv_qty;
  int          failures, comparisons, cycles;
  logic [31:0] rst_tab [6] = '{32'h00000001, 32'h00004000, 32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001};
  logic [31:0] grid_den [4] = '{32'h00004000, 32'h00008000, 32'h00008000, 32'h00001000};
  logic [31:0] grid_val [4] = '{32'h00000007, 32'h00000003, 32'h00000002, 32'h00000001};
  logic [31:0] grid_exp [4] = '{32'h00000007, 32'h00000002, 32'h00000001, 32'h00000004};

  uun_norm i_dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_PAR_WR(par_wr), .I_PAR_RD(par_rd), .I_PAR_IDX(par_idx),
    .I_PAR_SIDX(par_sidx), .I_PAR_WDATA(par_wdata), .O_PAR_ACK(par_ack), .O_PAR_ERR(par_err),
    .O_PAR_RDATA(par_rdata), .I_CONV_REQ(conv_req), .I_CONV_QTY(conv_qty), .I_CONV_TO_USER(conv_dir),
    .I_CONV_VAL(conv_val), .O_CONV_READY(conv_ready), .O_CONV_DONE(conv_done), .O_CONV_ERR(conv_err),
    .O_CONV_RES(conv_res), .I_ACT_POS(act_pos), .O_RESIDUAL(residual));
  uun_host_model i_host (.i_clk(clk), .o_wr(par_wr), .o_rd(par_rd), .o_idx(par_idx), .o_sidx(par_sidx),
    .o_wdata(par_wdata), .i_ack(par_ack), .i_err(par_err), .i_rdata(par_rdata));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard: a run far beyond the expected few thousand cycles is a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures = failures + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // register access with expected refusal flag and read data
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sidx, input logic [31:0] data,
                     input logic exp_err);
    logic a, e;
    logic [31:0] r;
    i_host.access(wr, idx, sidx, data, a, e, r);
    check({31'h0, a}, 32'h1);
    check({31'h0, e}, {31'h0, exp_err});
    if (!wr) check(r, data);
  endtask

  task automatic ratio(input logic [7:0] sidx_num, input logic [31:0] num, input logic [31:0] den);
    logic e;
    i_host.set_ratio(sidx_num, num, den, e);
    check({31'h0, e}, 32'h0);
  endtask

  // request held until taken while ready, then result after the fixed latency
  task automatic conv(input uun_qty_t q, input logic to_user, input logic [31:0] v, input logic [31:0] exp,
                      input logic exp_err);
    int k;
    @(posedge clk);
    conv_req <= 1'b1;
    conv_qty <= q;
    conv_dir <= to_user;
    conv_val <= v;
    for (k = 0; k < 500; k++) begin
      @(negedge clk);
      if (conv_ready === 1'b1) break;
    end
    @(posedge clk);
    conv_req <= 1'b0;
    conv_val <= ~v;
    for (k = 1; k < 100; k++) begin
      @(negedge clk);
      if (conv_done === 1'b1) break;
    end
    check(k, 83);
    check(conv_res, exp);
    check({31'h0, conv_err}, {31'h0, exp_err});
  endtask

  initial begin
    nrst = 1'b0;
    conv_req = 1'b0;
    conv_qty = UUN_QTY_POS;
    conv_dir = 1'b0;
    conv_val = 32'h00000000;
    act_pos = 32'h00000000;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, 16'h001D, 8'h07 + 8'(i), rst_tab[i], 1'b0);
    end
    $display("test reset values done");
    conv(UUN_QTY_POS, 1'b0, 32'h00000005, 32'h00000005, 1'b0);
    conv(UUN_QTY_POS, 1'b1, 32'hFFFFFFF6, 32'hFFFFFFF6, 1'b0);
    conv(UUN_QTY_VEL, 1'b0, 32'h00000064, 32'h00000064, 1'b0);
    conv(UUN_QTY_ACC, 1'b1, 32'h00000007, 32'h00000007, 1'b0);
    $display("test default scaling done");
    acc(1'b1, 16'h001F, 8'h25, 32'h00000001, 1'b1);
    acc(1'b1, 16'h001D, 8'h06, 32'h00000001, 1'b1);
    acc(1'b1, 16'h001D, 8'h07, 32'h00000000, 1'b1);
    acc(1'b1, 16'h001D, 8'h0A, 32'hFFFFFFFF, 1'b1);
    acc(1'b0, 16'h001D, 8'h0D, 32'h00000000, 1'b1);
    acc(1'b0, 16'h001D, 8'h08, 32'h00004000, 1'b0);
    acc(1'b0, 16'h001D, 8'h0A, 32'h00000001, 1'b0);
    $display("test refused accesses done");
    // homing search distance of 900 units, taken to increments under the old ratio
    conv(UUN_QTY_POS, 1'b0, 32'h00000384, 32'h00000384, 1'b0);
    acc(1'b1, 16'h001D, 8'h07, 32'h00000003, 1'b0);
    acc(1'b0, 16'h001D, 8'h07, 32'h00000001, 1'b0);
    acc(1'b1, 16'h001D, 8'h08, 32'h00000457, 1'b0);
    acc(1'b0, 16'h001D, 8'h07, 32'h00000003, 1'b0);
    conv(UUN_QTY_POS, 1'b0, 32'h00000384, 32'h00009B89, 1'b0);
    conv(UUN_QTY_POS, 1'b0, 32'hFFFFFC7C, 32'hFFFF6477, 1'b0);
    conv(UUN_QTY_POS, 1'b1, 32'h00009B89, 32'h00000384, 1'b0);
    // same homing distance rescaled into the new units; a host raises it if referencing fails
    conv(UUN_QTY_POS, 1'b1, 32'h00000384, 32'h00000014, 1'b0);
    $display("test paired ratio done");
    for (int i = 0; i < 4; i++) begin
      ratio(8'h07, 32'h00000001, grid_den[i]);
      conv(UUN_QTY_POS, 1'b0, grid_val[i], grid_exp[i], 1'b0);
    end
    $display("test position grids done");
    ratio(8'h09, 32'h7FFFFFFF, 32'h7FFFFFFF);
    conv(UUN_QTY_VEL, 1'b0, 32'h7FFFFFFF, 32'h7FFFFFFF, 1'b0);
    ratio(8'h0B, 32'h00000002, 32'h00000001);
    conv(UUN_QTY_ACC, 1'b0, 32'h40000000, 32'h7FFFFFFF, 1'b1);
    conv(UUN_QTY_ACC, 1'b1, 32'h40000000, 32'h20000000, 1'b0);
    conv(UUN_QTY_VEL, 1'b1, 32'h00000010, 32'h00000010, 1'b0);
    $display("test wide products done");
    ratio(8'h07, 32'h00000001, 32'h00000400);
    act_pos <= 32'h00003E85;
    repeat (400) @(posedge clk);
    acc(1'b0, 16'h001F, 8'h25, 32'h00000005, 1'b0);
    check(residual, 32'h00000005);
    act_pos <= 32'hFFFFC17B;
    repeat (400) @(posedge clk);
    acc(1'b0, 16'h001F, 8'h25, 32'hFFFFFFFB, 1'b0);
    @(negedge clk);
    check(residual, 32'hFFFFFFFB);
    $display("test residual done");
    give_verdict();
  end
endmodule
`default_nettype wire
